// ==== rtl/asg_pkg.sv ====
// Package of constants and types for the address space generator.
package asg_pkg;
    // Status codes on the space status lines.
    localparam logic [3:0] ST_INSTR = 4'h_c;
    localparam logic [3:0] ST_INSTR_FIRST = 4'h_d;
    localparam logic [3:0] ST_DATA = 4'h_8;
    localparam logic [3:0] ST_STACK = 4'h_a;
    localparam logic [3:0] ST_STD_IO = 4'h_2;
    localparam logic [3:0] ST_SPC_IO = 4'h_3;
    localparam logic [3:0] ST_IDLE = 4'h_0;
    // Flag and control word fields.
    localparam int FCW_SEG_BIT = 15;
    localparam int FCW_SYS_BIT = 14;
    localparam logic [15:0] FCW_RESET = 16'h_0000;
    // Reset program status: three reserved words.
    localparam int RESET_WORDS = 3;
    localparam logic [15:0] RESET_BASE = 16'h_0000;
    // Address widths.
    localparam int SEG_W = 7;
    localparam int OFF_W = 16;
    localparam int IO_W = 16;
    // Avalon register offsets (byte addresses).
    localparam logic [4:0] REG_CTRL = 5'h_00;
    localparam logic [4:0] REG_ACCESS = 5'h_04;
    localparam logic [4:0] REG_ADDR = 5'h_08;
    localparam logic [4:0] REG_STATUS = 5'h_0c;
    localparam logic [4:0] REG_DATA = 5'h_10;
    // Control register fields.
    localparam int CTRL_SEGVAR_BIT = 0;
    // Access register fields.
    localparam int ACC_KIND_LSB = 0;
    localparam int ACC_WORD_BIT = 4;
    localparam int ACC_FIRST_BIT = 5;
    localparam int ACC_SEGLD_BIT = 6;
    // Bus transaction length in cycles; the first cycle carries the segment only, except reset word reads, which carry the address too.
    localparam int XFER_CYCLES = 3;
    typedef enum logic [2:0] {
        ASG_K_FETCH, ASG_K_DATA, ASG_K_STACK, ASG_K_STD_IO, ASG_K_SPC_IO
    } asg_kind_t;
    typedef enum {
        ASG_RUN, ASG_STOP_REFRESH, ASG_BUS_DISC
    } asg_opstate_t;
endpackage : asg_pkg

// ==== rtl/asg_core.sv ====
// Address space generator: status codes, address forming and operating states.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Instruction fetch drives status 1100 or 1101.
// - Memory operands drive status 1000 or 1010.
// - Standard I/O ports drive status 0010.
// - Support chip ports drive status 0011.
// - Normal/system line follows privilege bit; reset word reads always drive system.
// - I/O addresses 16 bits, port width sizes.
// - I/O space 64K ports, odd allowed.
// - Bit n has weight two to n.
// - Lowest byte address holds most significant byte.
// - Word addresses even; byte addresses any.
// - Three reset words read after reset.
// - Flat variant makes 16-bit addresses.
// - Segmented: 7-bit segment plus 16-bit offset.
// - Multi-byte access never crosses segment.
// - Segmented address held in 32-bit word.
// - Flat mode on segmented variant uses PC segment.
// - Segment number driven early in transaction.
// - Page abort stops instruction, saves restart data; here abort is only flagged and transfers run on.
// - Three states; stop or refresh enters stop.
// - Leave stop when both causes clear.
// - Bus request wins, outputs disconnect.
module asg_core #(
    parameter int REFRESH_PERIOD = 64
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic stop_req_in,
    input wire logic bus_req_in,
    input wire logic abort_in,
    output logic [3:0] space_status_lines_out,
    output logic normal_mode_out,
    output logic [6:0] segment_out,
    output logic [15:0] address_out,
    output logic word_out,
    output logic addr_strobe_out,
    output logic bus_oe_out,
    output logic bus_ack_out,
    output logic [1:0] op_state_out
);
    import asg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for pins.
    logic [1:0] stop_sync, busreq_sync, abort_sync;
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            stop_sync <= 2'h_0;
            busreq_sync <= 2'h_0;
            abort_sync <= 2'h_0;
        end else begin
            stop_sync <= {stop_sync[0], stop_req_in};
            busreq_sync <= {busreq_sync[0], bus_req_in};
            abort_sync <= {abort_sync[0], abort_in};
        end
    end
    logic stop_s, busreq_s, abort_s;
    assign stop_s = stop_sync[1];
    assign busreq_s = busreq_sync[1];
    assign abort_s = abort_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.
    function automatic logic [3:0] kind_code(input logic [2:0] kind, input logic first);
        logic [3:0] code;
        code = ST_IDLE;
        unique case (kind)
            ASG_K_FETCH: code = first ? ST_INSTR_FIRST : ST_INSTR;
            ASG_K_DATA: code = ST_DATA;
            ASG_K_STACK: code = ST_STACK;
            ASG_K_STD_IO: code = ST_STD_IO;
            ASG_K_SPC_IO: code = ST_SPC_IO;
            default: code = ST_IDLE;
        endcase
        return code;
    endfunction : kind_code

    function automatic logic is_io(input logic [2:0] kind);
        return (kind == ASG_K_STD_IO) || (kind == ASG_K_SPC_IO);
    endfunction : is_io

    ////////////////////////////////////////////////////////////////////////////////
    // Operating state machine and refresh counter.
    asg_opstate_t op_state;
    logic [15:0] refresh_cnt;
    logic refresh_pend;
    logic refresh_done;
    logic xfer_busy;
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            refresh_cnt <= 16'h_0000;
            refresh_pend <= 1'b0;
        end else begin
            if (refresh_cnt == 16'(REFRESH_PERIOD - 1)) begin
                refresh_cnt <= 16'h_0000;
            end else begin
                refresh_cnt <= refresh_cnt + 16'h_0001;
            end
            // A new request wins over the completion of the previous one.
            if (refresh_cnt == 16'(REFRESH_PERIOD - 1)) begin
                refresh_pend <= 1'b1;
            end else if (refresh_done) begin
                refresh_pend <= 1'b0;
            end
        end
    end
    assign refresh_done = (op_state == ASG_STOP_REFRESH) && refresh_pend;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            op_state <= ASG_RUN;
        end else if (busreq_s && !xfer_busy) begin
            op_state <= ASG_BUS_DISC;
        end else begin
            unique case (op_state)
                ASG_RUN: begin
                    if ((stop_s || refresh_pend) && !xfer_busy) begin
                        op_state <= ASG_STOP_REFRESH;
                    end
                end
                ASG_STOP_REFRESH: begin
                    if (!stop_s && !(refresh_pend && !refresh_done)) begin
                        op_state <= ASG_RUN;
                    end
                end
                ASG_BUS_DISC: op_state <= ASG_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program status: flag and control word and program counter segment.
    logic [15:0] flag_control_word;
    logic [6:0] pc_segment;
    logic seg_variant;
    logic [1:0] reset_fetch_cnt;
    logic reset_fetch;
    assign reset_fetch = (reset_fetch_cnt != 2'(RESET_WORDS));

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon slave. Software posts an access; it is refused by waitrequest while
    // a transaction runs, so a request is never lost and status stays stable.
    logic [2:0] acc_kind;
    logic acc_word, acc_first, acc_segld;
    logic [31:0] acc_addr;
    logic [15:0] data_reg;
    logic post_access;
    logic can_issue;
    logic [1:0] xfer_cnt;
    logic align_err;
    logic abort_seen;
    logic wr_ok;
    logic run_clear;
    logic [2:0] post_kind;
    logic post_word, post_first, post_segld;
    // Nothing new starts while a stop, refresh or bus request is about to take
    // the bus, so no transfer ever runs outside the running state.
    assign run_clear = (op_state == ASG_RUN) && !busreq_s && !stop_s && !refresh_pend;
    assign can_issue = !xfer_busy && run_clear && !reset_fetch;
    // The posting edge also loads the access register, so the transfer takes
    // its kind and flags straight from the write data.
    assign post_kind = avs_writedata_in[ACC_KIND_LSB +: 3];
    assign post_word = avs_writedata_in[ACC_WORD_BIT];
    assign post_first = avs_writedata_in[ACC_FIRST_BIT];
    assign post_segld = avs_writedata_in[ACC_SEGLD_BIT];
    assign wr_ok = avs_write_in && !(avs_address_in == REG_ACCESS && !can_issue);
    assign post_access = wr_ok && (avs_address_in == REG_ACCESS);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            seg_variant <= 1'b0;
            acc_kind <= 3'h_0;
            acc_word <= 1'b0;
            acc_first <= 1'b0;
            acc_segld <= 1'b0;
            acc_addr <= 32'h_0000_0000;
            data_reg <= 16'h_0000;
            flag_control_word <= FCW_RESET;
        end else if (wr_ok) begin
            unique case (avs_address_in)
                REG_CTRL: seg_variant <= avs_writedata_in[CTRL_SEGVAR_BIT];
                REG_ACCESS: begin
                    acc_kind <= avs_writedata_in[ACC_KIND_LSB +: 3];
                    acc_word <= avs_writedata_in[ACC_WORD_BIT];
                    acc_first <= avs_writedata_in[ACC_FIRST_BIT];
                    acc_segld <= avs_writedata_in[ACC_SEGLD_BIT];
                end
                // Segmented address lives in a 32-bit long word.
                REG_ADDR: acc_addr <= {1'b0, avs_writedata_in[30:24], 8'h_00,
                    avs_writedata_in[15:0]};
                REG_DATA: flag_control_word <= avs_writedata_in[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            avs_readdata_out <= 32'h_0000_0000;
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= 1'b1;
            if ((avs_read_in || avs_write_in) && avs_waitrequest_out &&
                !(avs_write_in && avs_address_in == REG_ACCESS && !can_issue)) begin
                avs_waitrequest_out <= 1'b0;
            end
            if (avs_read_in && avs_waitrequest_out) begin
                unique case (avs_address_in)
                    REG_CTRL: avs_readdata_out <= {31'h_0, seg_variant};
                    REG_ACCESS: avs_readdata_out <= {25'h_0, acc_segld, acc_first,
                        acc_word, 1'b0, acc_kind};
                    REG_ADDR: avs_readdata_out <= acc_addr;
                    REG_STATUS: avs_readdata_out <= {20'h_0, align_err, abort_seen,
                        pc_segment, xfer_busy, op_state_out};
                    REG_DATA: avs_readdata_out <= {16'h_0, flag_control_word};
                    default: avs_readdata_out <= 32'h_0000_0000;
                endcase
            end
        end
    end
    // The write above is taken at every edge the request is held, with waitrequest high or low, except an access post while can_issue is low;
    // posting registers on wr_ok is safe because the master holds the request.

    // An abort is kept until the next access is posted, so software still sees
    // it after the pin drops; the access registers stay as restart data.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            abort_seen <= 1'b0;
        end else if (abort_s) begin
            abort_seen <= 1'b1;
        end else if (post_access && avs_waitrequest_out) begin
            abort_seen <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transaction sequencer.
    logic reset_xfer;
    logic [15:0] next_offset;
    always_comb begin
        next_offset = acc_addr[15:0];
        // The even address names the word and its high byte.
        // Word accesses to memory force even addresses; I/O ports may be odd.
        if (acc_word && !is_io(acc_kind)) begin
            next_offset = {acc_addr[15:1], 1'b0};
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            xfer_busy <= 1'b0;
            xfer_cnt <= 2'h_0;
            reset_fetch_cnt <= 2'h_0;
            pc_segment <= 7'h_00;
            align_err <= 1'b0;
            reset_xfer <= 1'b0;
            space_status_lines_out <= ST_IDLE;
            normal_mode_out <= 1'b0;
            segment_out <= 7'h_00;
            address_out <= 16'h_0000;
            word_out <= 1'b0;
            addr_strobe_out <= 1'b0;
        end else if (!xfer_busy && reset_fetch && run_clear) begin
            // Reset program status fetch from the reserved words.
            xfer_busy <= 1'b1;
            reset_xfer <= 1'b1;
            xfer_cnt <= 2'h_0;
            reset_fetch_cnt <= reset_fetch_cnt + 2'h_1;
            space_status_lines_out <= ST_DATA;
            normal_mode_out <= 1'b0;
            segment_out <= 7'h_00;
            address_out <= RESET_BASE + {13'h_0, reset_fetch_cnt, 1'b0};
            word_out <= 1'b1;
            addr_strobe_out <= 1'b0;
        end else if (!xfer_busy && post_access && avs_waitrequest_out) begin
            xfer_busy <= 1'b1;
            xfer_cnt <= 2'h_0;
            reset_xfer <= 1'b0;
            align_err <= post_word && !is_io(post_kind) && acc_addr[0];
            // Segment changes only on an explicit load.
            if (post_segld && seg_variant) begin
                pc_segment <= acc_addr[30:24];
            end
            space_status_lines_out <= kind_code(post_kind, post_first);
            normal_mode_out <= !flag_control_word[FCW_SYS_BIT];
            // Segment goes out first, ahead of the offset.
            if (!seg_variant || is_io(post_kind)) begin
                segment_out <= 7'h_00;
            end else if (flag_control_word[FCW_SEG_BIT]) begin
                segment_out <= acc_addr[30:24];
            end else begin
                segment_out <= pc_segment;
            end
            address_out <= 16'h_0000;
            word_out <= post_word;
            addr_strobe_out <= 1'b0;
        end else if (xfer_busy) begin
            // Status and mode stay put until the end.
            if (xfer_cnt == 2'h_0) begin
                // A reset word read keeps the address it was started with.
                if (!reset_xfer) begin
                    address_out <= next_offset;
                end
                addr_strobe_out <= 1'b1;
            end
            if (xfer_cnt == 2'(XFER_CYCLES - 1)) begin
                xfer_busy <= 1'b0;
                addr_strobe_out <= 1'b0;
                space_status_lines_out <= ST_IDLE;
            end
            xfer_cnt <= xfer_cnt + 2'h_1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            bus_oe_out <= 1'b0;
            bus_ack_out <= 1'b0;
            op_state_out <= 2'h_0;
        end else begin
            bus_oe_out <= (op_state != ASG_BUS_DISC) && !busreq_s;
            bus_ack_out <= (op_state == ASG_BUS_DISC);
            op_state_out <= 2'(op_state);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.
    a_fetch_code: assert property (@(posedge mclk_in) disable iff (reset_in)
        (addr_strobe_out && space_status_lines_out[3:2] == 2'b11)
        |-> space_status_lines_out[3:1] == 3'b110)
        else $error("fetch status code wrong");
    a_io_word_seg: assert property (@(posedge mclk_in) disable iff (reset_in)
        (addr_strobe_out && space_status_lines_out[3:1] == 3'b001) |-> segment_out == 7'h_00)
        else $error("io address carries segment");
    a_even_word: assert property (@(posedge mclk_in) disable iff (reset_in)
        (addr_strobe_out && word_out && space_status_lines_out[3]) |-> !address_out[0])
        else $error("odd word address");
    a_status_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
        (addr_strobe_out && $past(addr_strobe_out))
        |-> $stable(space_status_lines_out) && $stable(normal_mode_out)
            && $stable(segment_out))
        else $error("status changed mid transaction");
    a_seg_early: assert property (@(posedge mclk_in) disable iff (reset_in)
        $rose(xfer_busy) |-> !addr_strobe_out ##1 (addr_strobe_out && $stable(segment_out)))
        else $error("segment not early");
    a_busreq_wins: assert property (@(posedge mclk_in) disable iff (reset_in)
        (busreq_s && !xfer_busy) |=> op_state == ASG_BUS_DISC ##1 !bus_oe_out)
        else $error("bus request ignored");
    a_stop_enter: assert property (@(posedge mclk_in) disable iff (reset_in)
        (op_state == ASG_RUN && stop_s && !busreq_s && !xfer_busy)
        |=> op_state == ASG_STOP_REFRESH)
        else $error("stop not entered");
    a_stop_leave: assert property (@(posedge mclk_in) disable iff (reset_in)
        (op_state == ASG_STOP_REFRESH && stop_s && !busreq_s) |=> op_state != ASG_RUN)
        else $error("left stop early");
    a_reset_words: assert property (@(posedge mclk_in) disable iff (reset_in)
        $fell(reset_in) |-> ##13 reset_fetch_cnt == 2'(RESET_WORDS))
        else $error("reset words not read");
    a_mode_line: assert property (@(posedge mclk_in) disable iff (reset_in)
        ($rose(xfer_busy) && reset_fetch_cnt == 2'(RESET_WORDS) && !$past(reset_fetch))
        |-> normal_mode_out == !$past(flag_control_word[FCW_SYS_BIT]))
        else $error("normal line wrong");
    c_fetch: cover property (@(posedge mclk_in)
        addr_strobe_out && space_status_lines_out == ST_INSTR);
    c_io: cover property (@(posedge mclk_in)
        addr_strobe_out && space_status_lines_out == ST_SPC_IO);
    c_stop: cover property (@(posedge mclk_in) op_state == ASG_STOP_REFRESH && stop_s);
    c_disc: cover property (@(posedge mclk_in) op_state == ASG_BUS_DISC);
endmodule : asg_core
`default_nettype wire

// ==== sim/asg_far_model.sv ====
// Far-side model: bus watcher for memory and translator, and request source.
`timescale 1ns/1ps
`default_nettype none
module asg_far_model (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [3:0] status_in,
    input wire logic normal_in,
    input wire logic [6:0] segment_in,
    input wire logic [15:0] address_in,
    input wire logic word_in,
    input wire logic strobe_in,
    input wire logic stop_cmd_in,
    input wire logic bus_cmd_in,
    input wire logic abort_cmd_in,
    output logic stop_req_out,
    output logic bus_req_out,
    output logic abort_out
);
    logic [28:0] log_q[$];
    int faults = 0;
    int warns = 0;
    int priv_hits = 0;
    logic strobe_d = 1'b0;
    logic [6:0] seg_d = 7'h_00;
    logic [11:0] held = 12'h_000;
    logic [22:0] bank_addr;
    ////////////////////////////////////////////////////////////
    // Requests move only just after an edge, as a real party would.
    always @(posedge mclk_in) begin
        stop_req_out <= stop_cmd_in && !reset_in;
        bus_req_out <= bus_cmd_in && !reset_in;
        abort_out <= abort_cmd_in && !reset_in;
    end
    // Without a translator the segment serves as the bank number.
    assign bank_addr = {segment_in, address_in};
    always @(posedge mclk_in) begin
        strobe_d <= strobe_in && !reset_in;
        seg_d <= segment_in;
        if (strobe_in && !strobe_d) begin
            log_q.push_back({normal_in, word_in, status_in, segment_in, address_in});
            held <= {normal_in, status_in, segment_in};
            // This model marks the upper half of the segments as system only.
            if (status_in[3] && bank_addr[22] && normal_in) priv_hits++;
            // Stack pages are 2048 bytes; the last 256 bytes raise a warning.
            if (status_in == 4'h_a && bank_addr[10:0] >= 11'h_700) warns++;
            if (segment_in !== seg_d) faults++;
        end
        if (strobe_in && strobe_d && {normal_in, status_in, segment_in} !== held) faults++;
    end
endmodule : asg_far_model
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking testbench for the address space generator.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import asg_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [4:0] avs_address_in = 5'h_00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h_0000_0000;
    logic [31:0] avs_readdata_out, rd;
    logic avs_waitrequest_out, stop_req_in, bus_req_in, abort_in, normal_mode_out;
    logic [3:0] space_status_lines_out;
    logic [6:0] segment_out;
    logic [6:0] pc_seg = 7'h_00;
    logic [15:0] address_out;
    logic word_out, addr_strobe_out, bus_oe_out, bus_ack_out;
    logic [1:0] op_state_out;
    logic stop_cmd = 1'b0;
    logic bus_cmd = 1'b0;
    logic abort_cmd = 1'b0;
    int miscompares = 0;
    int checks_done = 0;
    int seen = 0;
    int exp_warns = 0;
    int exp_priv = 0;
    always #2 mclk_in = ~mclk_in;
    asg_core #(.REFRESH_PERIOD(16)) DUT (.mclk_in(mclk_in), .reset_in(reset_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .stop_req_in(stop_req_in), .bus_req_in(bus_req_in), .abort_in(abort_in),
        .space_status_lines_out(space_status_lines_out), .normal_mode_out(normal_mode_out),
        .segment_out(segment_out), .address_out(address_out), .word_out(word_out),
        .addr_strobe_out(addr_strobe_out), .bus_oe_out(bus_oe_out),
        .bus_ack_out(bus_ack_out), .op_state_out(op_state_out));
    asg_far_model far (.mclk_in(mclk_in), .reset_in(reset_in),
        .status_in(space_status_lines_out), .normal_in(normal_mode_out),
        .segment_in(segment_out), .address_in(address_out), .word_in(word_out),
        .strobe_in(addr_strobe_out), .stop_cmd_in(stop_cmd), .bus_cmd_in(bus_cmd),
        .abort_cmd_in(abort_cmd), .stop_req_out(stop_req_in), .bus_req_out(bus_req_in),
        .abort_out(abort_in));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low, then releases it.
    task automatic av_req(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            @(posedge mclk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 5000);
        rd = avs_readdata_out;
        chk(32'(n < 5000), 32'h_0000_0001, "bus answer");
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : av_req
    task automatic wait_xfer(input logic [28:0] exp);
        int n;
        n = 0;
        while (far.log_q.size() <= seen && n < 2000) begin
            @(posedge mclk_in);
            n++;
        end
        chk({3'h_0, far.log_q[seen]}, {3'h_0, exp}, "transfer");
        seen++;
    endtask : wait_xfer
    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        while (op_state_out !== s && n < 80) begin
            @(posedge mclk_in);
            n++;
        end
        chk({30'h_0000_0000, op_state_out}, {30'h_0000_0000, s}, "state");
    endtask : wait_state
    function automatic logic [28:0] exp_xfer(input int k, input logic f, w, sys,
        input logic [6:0] segmented_mode_bit, input logic [15:0] a);
        logic [3:0] st;
        st = (k == 0) ? (f ? 4'h_d : 4'h_c) : (k == 1) ? 4'h_8 : (k == 2) ? 4'h_a
            : (k == 3) ? 4'h_2 : 4'h_3;
        if (k >= 3) segmented_mode_bit = 7'h_00;
        if (w && k < 3) a[0] = 1'b0;
        return {!sys, w, st, segmented_mode_bit, a};
    endfunction : exp_xfer
    task automatic do_access(input int k, input logic f, w, sys, sv, sm, ld,
        input logic [6:0] sg, input logic [15:0] a);
        logic [6:0] s;
        av_req(1'b1, REG_CTRL, {31'h_0000_0000, sv});
        av_req(1'b1, REG_DATA, {16'h_0000, sm, sys, 14'h_0000});
        av_req(1'b1, REG_ADDR, {1'b0, sg, 8'h_00, a});
        av_req(1'b1, REG_ACCESS, {25'h_000_0000, ld, f, w, 1'b0, k[2:0]});
        s = !sv ? 7'h_00 : (sm ? sg : pc_seg);
        if (ld && sv) pc_seg = sg;
        if (k == 2 && a[10:0] >= 11'h_700) exp_warns++;
        if (k < 3 && s[6] && !sys) exp_priv++;
        wait_xfer(exp_xfer(k, f, w, sys, s, a));
    endtask : do_access
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////
    initial begin
        int k;
        logic [5:0] rb;
        void'($urandom(32'h_8ae4_0fea));
        repeat (8) @(posedge mclk_in);
        chk({28'h_000_0000, avs_waitrequest_out, bus_oe_out, op_state_out}, 32'h_8, "reset");
        reset_in <= 1'b0;
        for (int i = 0; i < 3; i++) wait_xfer({2'b01, 4'h_8, 7'h_00, 16'(2 * i)});
        repeat (30) @(posedge mclk_in);
        chk(32'(far.log_q.size()), 32'h_0000_0003, "reset words");
        $display("test reset done");
        for (int i = 0; i < 6; i++) do_access(i % 5, i == 5, 1'b1, i[0], 1'b0, 1'b0, 1'b0,
            7'h_00, 16'h_fff1 + 16'(2 * i));
        av_req(1'b0, REG_STATUS, 32'h_0);
        chk({31'h_0, rd[11]}, 32'h_1, "align");
        av_req(1'b0, 5'h_14, 32'h_0);
        chk(rd, 32'h_0, "unmapped");
        $display("test codes done");
        do_access(0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 7'h_55, 16'h_2000);
        do_access(1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 7'h_12, 16'h_0100);
        do_access(1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 7'h_7f, 16'h_ffff);
        av_req(1'b0, REG_STATUS, 32'h_0);
        chk({25'h_0, rd[9:3]}, {25'h_0, pc_seg}, "pc segment");
        for (int i = 0; i < 24; i++) begin
            k = $urandom_range(4);
            rb = 6'($urandom);
            do_access(k, rb[0] && k == 0, rb[1], rb[2], rb[3], rb[4], rb[5] & rb[3] & rb[4],
                7'($urandom), 16'($urandom));
        end
        $display("test segments done");
        stop_cmd <= 1'b1;
        wait_state(2'd1);
        fork
            do_access(1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h_00, 16'h_0042);
            begin
                repeat (40) @(posedge mclk_in);
                chk(32'(far.log_q.size()), 32'(seen), "refused");
                stop_cmd <= 1'b0;
            end
        join
        stop_cmd <= 1'b1;
        bus_cmd <= 1'b1;
        wait_state(2'd2);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk_in);
            chk({29'h_0, op_state_out, bus_oe_out}, 32'h_4, "disconnect");
            chk({31'h_0, bus_ack_out}, 32'h_1, "bus ack");
        end
        bus_cmd <= 1'b0;
        wait_state(2'd1);
        stop_cmd <= 1'b0;
        wait_state(2'd0);
        wait_state(2'd1);
        $display("test states done");
        abort_cmd <= 1'b1;
        av_req(1'b1, REG_ACCESS, 32'h_0000_0001);
        repeat (12) @(posedge mclk_in);
        abort_cmd <= 1'b0;
        av_req(1'b0, REG_STATUS, 32'h_0);
        chk({31'h_0, rd[10]}, 32'h_1, "abort");
        seen = far.log_q.size();
        chk(32'(far.faults), 32'h_0, "bus hold");
        chk(32'(far.warns), 32'(exp_warns), "stack warn");
        chk(32'(far.priv_hits), 32'(exp_priv), "system segment");
        $display("test abort done");
        test_done();
    end
    initial begin
        repeat (40000) @(posedge mclk_in);
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end
endmodule : tb
`default_nettype wire
